// ### core/iep_pkg.sv
// Constants and helpers shared by the interrupt enable and priority block
package iep_pkg;

  localparam int          NUM_SRC = 10;
  localparam int          ID_W    = 4;
  localparam int          EVT_W   = 4;

  // Register addresses in the special-function space
  localparam logic [7:0]  ADDR_PRIO_LOW_B  = 8'h91;
  localparam logic [7:0]  ADDR_PRIO_HIGH_B = 8'h92;
  localparam logic [7:0]  ADDR_ENABLE_A    = 8'hA8;
  localparam logic [7:0]  ADDR_PRIO_HIGH_A = 8'hB7;
  localparam logic [7:0]  ADDR_PRIO_LOW_A  = 8'hB8;
  localparam logic [7:0]  ADDR_ENABLE_B    = 8'hE8;
  localparam logic [7:0]  ADDR_EVT_STATUS  = 8'hF9;
  localparam logic [7:0]  ADDR_EVT_CLEAR   = 8'hFA;
  localparam logic [7:0]  ADDR_EVT_ENABLE  = 8'hFB;

  // Reset values
  localparam logic [7:0]  RST_ENABLE = 8'h00;
  localparam logic [7:0]  RST_PRIO   = 8'h00;
  localparam logic [7:0]  RST_EVT    = 8'h00;

  // Writable bits of the second enable and priority registers
  localparam logic [7:0]  ENABLE_B_USED = 8'h07;
  localparam logic [7:0]  PRIO_B_USED   = 8'h03;

  // Field positions, first enable and first priority registers
  localparam int          BIT_MASTER = 7;
  localparam int          BIT_T2_A   = 7;
  localparam int          BIT_PCA    = 6;
  localparam int          BIT_I2C1   = 5;
  localparam int          BIT_SER    = 4;
  localparam int          BIT_T1     = 3;
  localparam int          BIT_EXT1   = 2;
  localparam int          BIT_T0     = 1;
  localparam int          BIT_EXT0   = 0;
  // Second enable register
  localparam int          BIT_SPI_EN  = 2;
  localparam int          BIT_I2C2_EN = 1;
  localparam int          BIT_T2_EN   = 0;
  // Second priority registers
  localparam int          BIT_SPI_PRIO  = 1;
  localparam int          BIT_I2C2_PRIO = 0;

  // Source numbers follow the polling order, lowest number wins a tie
  localparam logic [3:0]  SRC_EXT0 = 4'h0;
  localparam logic [3:0]  SRC_I2C1 = 4'h1;
  localparam logic [3:0]  SRC_T0   = 4'h2;
  localparam logic [3:0]  SRC_EXT1 = 4'h3;
  localparam logic [3:0]  SRC_T1   = 4'h4;
  localparam logic [3:0]  SRC_SER  = 4'h5;
  localparam logic [3:0]  SRC_T2   = 4'h6;
  localparam logic [3:0]  SRC_PCA  = 4'h7;
  localparam logic [3:0]  SRC_SPI  = 4'h8;
  localparam logic [3:0]  SRC_I2C2 = 4'h9;

  // Event status bit positions
  localparam int          EVT_TAKEN   = 0;
  localparam int          EVT_NESTED  = 1;
  localparam int          EVT_RSVD_WR = 2;
  localparam int          EVT_BIT_REF = 3;

  // Level from the high and low priority bits, 3 is highest
  function automatic logic [1:0] iep_level(input logic hi, input logic lo);
    return {hi, lo};
  endfunction

  // Level plus one of the highest routine in service, 0 when idle
  function automatic logic [2:0] iep_threshold(input logic [3:0] busy);
    logic [2:0] t;
    t = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (busy[i]) begin
        t = 3'(i + 1);
      end
    end
    return t;
  endfunction

endpackage

// ### core/iep_arbiter.sv
// Picks the winning request: highest level, then polling order
`timescale 1ns/100ps
module iep_arbiter #(
  parameter int NUM_SRC = 10
) (
  input  wire logic [NUM_SRC-1:0]   req_i,
  input  wire logic [2*NUM_SRC-1:0] lvl_i,
  output logic                      found_o,
  output logic [3:0]                id_o,
  output logic [1:0]                level_o
);
  import iep_pkg::*;

  // Ascending scan keeps the first source on a tie
  always_comb begin
    found_o = 1'b0;
    id_o    = 4'h0;
    level_o = 2'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req_i[i] && (!found_o || lvl_i[2*i +: 2] > level_o)) begin
        found_o = 1'b1;
        id_o    = 4'(i);
        level_o = lvl_i[2*i +: 2];
      end
    end
  end

endmodule

// ### core/iep_events.sv
// Sticky event status with enable mask and one level interrupt
`timescale 1ns/100ps
module iep_events #(
  parameter int EVT_W = 4
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic [EVT_W-1:0] set_i,
  input  wire logic             clr_wr_i,
  input  wire logic             en_wr_i,
  input  wire logic [EVT_W-1:0] wdata_i,
  output logic      [EVT_W-1:0] status_o,
  output logic      [EVT_W-1:0] enable_o,
  output logic                  irq_o
);
  import iep_pkg::*;

  // Set beats a clear in the same cycle so no event is lost
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_o <= EVT_W'(RST_EVT);
    end else begin
      status_o <= (status_o & ~(clr_wr_i ? wdata_i : '0)) | set_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_o <= EVT_W'(RST_EVT);
    end else if (en_wr_i) begin
      enable_o <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((status_o & ~(clr_wr_i ? wdata_i : '0)) | set_i)
                 & (en_wr_i ? wdata_i : enable_o));
    end
  end

  property p_sticky;
    @(posedge clock_i) disable iff (!nrst_i)
    (status_o[0] && !(clr_wr_i && wdata_i[0])) |=> status_o[0];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event status bit lost without a clear");

endmodule

// ### core/iep_top.sv
// Interrupt enable and priority registers with level arbitration
`timescale 1ns/100ps
module iep_top (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] bit_reg_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic       bit_val_i,
  input  wire logic       bit_wr_i,
  input  wire logic [iep_pkg::NUM_SRC-1:0] src_req_i,
  input  wire logic       ack_i,
  input  wire logic       reti_i,
  output logic            irq_req_o,
  output logic      [3:0] irq_id_o,
  output logic      [1:0] irq_level_o,
  output logic      [3:0] in_service_o,
  output logic            event_irq_o
);
  import iep_pkg::*;

  logic [7:0]           enable_a_q;
  logic [7:0]           enable_b_q;
  logic [7:0]           prio_low_a_q;
  logic [7:0]           prio_high_a_q;
  logic [7:0]           prio_low_b_q;
  logic [7:0]           prio_high_b_q;
  logic [NUM_SRC-1:0]   en_vec;
  logic [NUM_SRC-1:0]   hi_vec;
  logic [NUM_SRC-1:0]   lo_vec;
  logic [2*NUM_SRC-1:0] lvl_vec;
  logic [NUM_SRC-1:0]   elig;
  logic                 found;
  logic [3:0]           win_id;
  logic [1:0]           win_lvl;
  logic [2:0]           thr;
  logic                 irq_req_d;
  logic                 byte_wr;
  logic                 bit_wr;
  logic [EVT_W-1:0]     evt_set;
  logic [EVT_W-1:0]     evt_status;
  logic [EVT_W-1:0]     evt_enable;
  logic [7:0]           rdata_d;
  logic                 rsvd_byte;
  logic                 rsvd_bit;

  // Single bit update used by every bit-writable register
  function automatic logic [7:0] bit_apply(input logic [7:0] v,
                                           input logic [2:0] sel,
                                           input logic       val);
    logic [7:0] r;
    r      = v;
    r[sel] = val;
    return r;
  endfunction

  // A byte write wins if both ports hit in one cycle
  assign byte_wr = wr_i;
  assign bit_wr  = bit_wr_i && !wr_i;

  // Per-source views in polling order
  assign en_vec[SRC_EXT0] = enable_a_q[BIT_EXT0];
  assign en_vec[SRC_I2C1] = enable_a_q[BIT_I2C1];
  assign en_vec[SRC_T0]   = enable_a_q[BIT_T0];
  assign en_vec[SRC_EXT1] = enable_a_q[BIT_EXT1];
  assign en_vec[SRC_T1]   = enable_a_q[BIT_T1];
  assign en_vec[SRC_SER]  = enable_a_q[BIT_SER];
  assign en_vec[SRC_T2]   = enable_b_q[BIT_T2_EN];
  assign en_vec[SRC_PCA]  = enable_a_q[BIT_PCA];
  assign en_vec[SRC_SPI]  = enable_b_q[BIT_SPI_EN];
  assign en_vec[SRC_I2C2] = enable_b_q[BIT_I2C2_EN];

  assign lo_vec[SRC_EXT0] = prio_low_a_q[BIT_EXT0];
  assign lo_vec[SRC_I2C1] = prio_low_a_q[BIT_I2C1];
  assign lo_vec[SRC_T0]   = prio_low_a_q[BIT_T0];
  assign lo_vec[SRC_EXT1] = prio_low_a_q[BIT_EXT1];
  assign lo_vec[SRC_T1]   = prio_low_a_q[BIT_T1];
  assign lo_vec[SRC_SER]  = prio_low_a_q[BIT_SER];
  assign lo_vec[SRC_T2]   = prio_low_a_q[BIT_T2_A];
  assign lo_vec[SRC_PCA]  = prio_low_a_q[BIT_PCA];
  assign lo_vec[SRC_SPI]  = prio_low_b_q[BIT_SPI_PRIO];
  assign lo_vec[SRC_I2C2] = prio_low_b_q[BIT_I2C2_PRIO];

  assign hi_vec[SRC_EXT0] = prio_high_a_q[BIT_EXT0];
  assign hi_vec[SRC_I2C1] = prio_high_a_q[BIT_I2C1];
  assign hi_vec[SRC_T0]   = prio_high_a_q[BIT_T0];
  assign hi_vec[SRC_EXT1] = prio_high_a_q[BIT_EXT1];
  assign hi_vec[SRC_T1]   = prio_high_a_q[BIT_T1];
  assign hi_vec[SRC_SER]  = prio_high_a_q[BIT_SER];
  assign hi_vec[SRC_T2]   = prio_high_a_q[BIT_T2_A];
  assign hi_vec[SRC_PCA]  = prio_high_a_q[BIT_PCA];
  assign hi_vec[SRC_SPI]  = prio_high_b_q[BIT_SPI_PRIO];
  assign hi_vec[SRC_I2C2] = prio_high_b_q[BIT_I2C2_PRIO];

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      lvl_vec[2*i +: 2] = iep_level(hi_vec[i], lo_vec[i]);
    end
  end

  // Master enable blocks every source at once
  assign elig = src_req_i & en_vec & {NUM_SRC{enable_a_q[BIT_MASTER]}};

  iep_arbiter #(
    .NUM_SRC (NUM_SRC)
  ) u_arbiter (
    .req_i   (elig),
    .lvl_i   (lvl_vec),
    .found_o (found),
    .id_o    (win_id),
    .level_o (win_lvl)
  );

  assign thr = iep_threshold(in_service_o);

  // Request drops for the cycle of an ack or return so the core never
  // sees a request computed from a stale in-service set
  assign irq_req_d = found && ((3'(win_lvl) + 3'h1) > thr)
                     && !ack_i && !reti_i;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_req_o   <= 1'b0;
      irq_id_o    <= 4'h0;
      irq_level_o <= 2'h0;
    end else begin
      irq_req_o   <= irq_req_d;
      irq_id_o    <= win_id;
      irq_level_o <= win_lvl;
    end
  end

  // In-service levels; a return retires the highest one unless an ack is taken in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_service_o <= 4'h0;
    end else if (ack_i && irq_req_o) begin
      in_service_o[irq_level_o] <= 1'b1;
    end else if (reti_i && thr != 3'h0) begin
      in_service_o[2'(thr - 3'h1)] <= 1'b0;
    end
  end

  // Reserved bits are dropped on write; nonzero ones are flagged
  always_comb begin
    rsvd_byte = 1'b0;
    if (byte_wr && addr_i == ADDR_ENABLE_B) begin
      rsvd_byte = |(wdata_i & ~ENABLE_B_USED);
    end else if (byte_wr && (addr_i == ADDR_PRIO_LOW_B ||
                             addr_i == ADDR_PRIO_HIGH_B)) begin
      rsvd_byte = |(wdata_i & ~PRIO_B_USED);
    end
  end

  assign rsvd_bit = bit_wr && bit_val_i &&
                    ((bit_reg_i == ADDR_ENABLE_B && !ENABLE_B_USED[bit_sel_i])
                  || (bit_reg_i == ADDR_PRIO_LOW_B && !PRIO_B_USED[bit_sel_i]));

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_a_q <= RST_ENABLE;
    end else if (byte_wr && addr_i == ADDR_ENABLE_A) begin
      enable_a_q <= wdata_i;
    end else if (bit_wr && bit_reg_i == ADDR_ENABLE_A) begin
      enable_a_q <= bit_apply(enable_a_q, bit_sel_i, bit_val_i);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_b_q <= RST_ENABLE;
    end else if (byte_wr && addr_i == ADDR_ENABLE_B) begin
      enable_b_q <= wdata_i & ENABLE_B_USED;
    end else if (bit_wr && bit_reg_i == ADDR_ENABLE_B) begin
      enable_b_q <= bit_apply(enable_b_q, bit_sel_i, bit_val_i)
                    & ENABLE_B_USED;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prio_low_a_q <= RST_PRIO;
    end else if (byte_wr && addr_i == ADDR_PRIO_LOW_A) begin
      prio_low_a_q <= wdata_i;
    end else if (bit_wr && bit_reg_i == ADDR_PRIO_LOW_A) begin
      prio_low_a_q <= bit_apply(prio_low_a_q, bit_sel_i, bit_val_i);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prio_low_b_q <= RST_PRIO;
    end else if (byte_wr && addr_i == ADDR_PRIO_LOW_B) begin
      prio_low_b_q <= wdata_i & PRIO_B_USED;
    end else if (bit_wr && bit_reg_i == ADDR_PRIO_LOW_B) begin
      prio_low_b_q <= bit_apply(prio_low_b_q, bit_sel_i, bit_val_i)
                      & PRIO_B_USED;
    end
  end

  // High priority registers ignore the bit port entirely
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prio_high_a_q <= RST_PRIO;
    end else if (byte_wr && addr_i == ADDR_PRIO_HIGH_A) begin
      prio_high_a_q <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prio_high_b_q <= RST_PRIO;
    end else if (byte_wr && addr_i == ADDR_PRIO_HIGH_B) begin
      prio_high_b_q <= wdata_i & PRIO_B_USED;
    end
  end

  // Events
  always_comb begin
    evt_set              = '0;
    evt_set[EVT_TAKEN]   = ack_i && irq_req_o;
    evt_set[EVT_NESTED]  = ack_i && irq_req_o && (in_service_o != 4'h0);
    evt_set[EVT_RSVD_WR] = rsvd_byte || rsvd_bit;
    evt_set[EVT_BIT_REF] = bit_wr && (bit_reg_i == ADDR_PRIO_HIGH_A ||
                                      bit_reg_i == ADDR_PRIO_HIGH_B);
  end

  iep_events #(
    .EVT_W (EVT_W)
  ) u_events (
    .clock_i  (clock_i),
    .nrst_i   (nrst_i),
    .set_i    (evt_set),
    .clr_wr_i (byte_wr && addr_i == ADDR_EVT_CLEAR),
    .en_wr_i  (byte_wr && addr_i == ADDR_EVT_ENABLE),
    .wdata_i  (wdata_i[EVT_W-1:0]),
    .status_o (evt_status),
    .enable_o (evt_enable),
    .irq_o    (event_irq_o)
  );

  // Read data; unmapped and write-only addresses read as zero
  always_comb begin
    unique case (addr_i)
      ADDR_ENABLE_A:    rdata_d = enable_a_q;
      ADDR_ENABLE_B:    rdata_d = enable_b_q;
      ADDR_PRIO_LOW_A:  rdata_d = prio_low_a_q;
      ADDR_PRIO_HIGH_A: rdata_d = prio_high_a_q;
      ADDR_PRIO_LOW_B:  rdata_d = prio_low_b_q;
      ADDR_PRIO_HIGH_B: rdata_d = prio_high_b_q;
      ADDR_EVT_STATUS:  rdata_d = 8'(evt_status);
      ADDR_EVT_ENABLE:  rdata_d = 8'(evt_enable);
      default:          rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Helper copies of the arbiter inputs for the order check
  logic [NUM_SRC-1:0]   elig_h;
  logic [2*NUM_SRC-1:0] lvl_h;
  logic                 beaten;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      elig_h <= '0;
      lvl_h  <= '0;
    end else begin
      elig_h <= elig;
      lvl_h  <= lvl_vec;
    end
  end

  always_comb begin
    beaten = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (elig_h[i] && (lvl_h[2*i +: 2] > irq_level_o ||
          (lvl_h[2*i +: 2] == irq_level_o && 4'(i) < irq_id_o))) begin
        beaten = 1'b1;
      end
    end
  end

  property p_master;
    @(posedge clock_i) disable iff (!nrst_i)
    irq_req_o |-> $past(enable_a_q[BIT_MASTER]);
  endproperty
  a_master: assert property (p_master)
    else $error("request raised with master enable clear");

  property p_gate;
    @(posedge clock_i) disable iff (!nrst_i)
    irq_req_o |-> elig_h[irq_id_o];
  endproperty
  a_gate: assert property (p_gate)
    else $error("request raised for a disabled source");

  property p_rsvd;
    @(posedge clock_i) disable iff (!nrst_i)
    (enable_b_q[7:3] == 5'h00) && (prio_low_b_q[7:2] == 6'h00)
    && (prio_high_b_q[7:2] == 6'h00);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit stored");

  property p_level;
    @(posedge clock_i) disable iff (!nrst_i)
    irq_req_o |-> irq_level_o == lvl_h[2*irq_id_o +: 2];
  endproperty
  a_level: assert property (p_level)
    else $error("request level does not match priority bits");

  property p_order;
    @(posedge clock_i) disable iff (!nrst_i)
    irq_req_o |-> !beaten;
  endproperty
  a_order: assert property (p_order)
    else $error("lower ranked source won arbitration");

  property p_preempt;
    @(posedge clock_i) disable iff (!nrst_i)
    irq_req_o |-> (3'(irq_level_o) + 3'h1) > iep_threshold(in_service_o);
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("request does not outrank routine in service");

  property p_bitset;
    @(posedge clock_i) disable iff (!nrst_i)
    (bit_wr && bit_reg_i == ADDR_PRIO_LOW_A)
    |=> prio_low_a_q[$past(bit_sel_i)] == $past(bit_val_i);
  endproperty
  a_bitset: assert property (p_bitset)
    else $error("bit write to low priority register lost");

  property p_nobit;
    @(posedge clock_i) disable iff (!nrst_i)
    (bit_wr && !byte_wr && bit_reg_i == ADDR_PRIO_HIGH_A)
    |=> $stable(prio_high_a_q) ##1 evt_status[EVT_BIT_REF];
  endproperty
  a_nobit: assert property (p_nobit)
    else $error("high priority register took a bit write");

  property p_read;
    @(posedge clock_i) disable iff (!nrst_i)
    (rd_i && addr_i == ADDR_ENABLE_A && !wr_i && !bit_wr_i)
    |=> (rdata_o == $past(enable_a_q))
        ##1 ($past(rd_i) || rdata_o == 8'h00);
  endproperty
  a_read: assert property (p_read)
    else $error("read data wrong one cycle after strobe");

endmodule

// ### testbench/iep_core_model.sv
// Behavioural core that takes interrupt requests and returns from them
`timescale 1ns/100ps
module iep_core_model (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       irq_req_i,
  input  wire logic [1:0] lat_i,
  input  wire logic       ret_i,
  output logic            ack_o,
  output logic            reti_o
);
  logic [1:0] wait_q;

  // Acks only a request that has stood lat_i cycles, so slow cores are seen
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q <= 2'h0;
      ack_o  <= 1'b0;
    end else if (ack_o || !irq_req_i) begin
      wait_q <= 2'h0;
      ack_o  <= 1'b0;
    end else if (wait_q >= lat_i) begin
      ack_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end

  // Return only when the bench orders it, one pulse per order
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reti_o <= 1'b0;
    end else begin
      reti_o <= ret_i;
    end
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench: registers, arbitration, nesting and events
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import iep_pkg::*;
  logic       clock_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic       bit_val_i = 1'b0, bit_wr_i = 1'b0, ret_cmd = 1'b0;
  logic       ack_i, reti_i, irq_req_o, event_irq_o, rd_seen = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, bit_reg_i = 8'h00, rdata_o;
  logic [2:0] bit_sel_i = 3'h0, thr = 3'h0;
  logic [1:0] lat = 2'h0, irq_level_o;
  logic [3:0] irq_id_o, in_service_o;
  logic [9:0] src_req_i = 10'h000;
  logic [7:0] en_a, en_b, pl_a, pl_b, ph_a, ph_b, e8;
  logic [7:0] rd_exp[$];
  logic [5:0] irq_exp[$];
  logic [5:0] e6;
  logic [6:0] w;
  logic [7:0] regs[7] = '{ADDR_ENABLE_A, ADDR_ENABLE_B, ADDR_PRIO_LOW_A,
    ADDR_PRIO_HIGH_A, ADDR_PRIO_LOW_B, ADDR_PRIO_HIGH_B, 8'h00};
  int         num_errors = 0, n_checks = 0;

  always #50 clock_i = ~clock_i;

  iep_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .bit_reg_i(bit_reg_i), .bit_sel_i(bit_sel_i), .bit_val_i(bit_val_i),
    .bit_wr_i(bit_wr_i), .src_req_i(src_req_i), .ack_i(ack_i),
    .reti_i(reti_i), .irq_req_o(irq_req_o), .irq_id_o(irq_id_o),
    .irq_level_o(irq_level_o), .in_service_o(in_service_o),
    .event_irq_o(event_irq_o));
  iep_core_model core (.clock_i(clock_i), .nrst_i(nrst_i),
    .irq_req_i(irq_req_o), .lat_i(lat), .ret_i(ret_cmd), .ack_o(ack_i),
    .reti_o(reti_i));

  // Results are matched in order against what the drivers noted
  always @(posedge clock_i) begin
    if (rd_seen) begin
      e8 = rd_exp.pop_front();
      `CHK(rdata_o, e8)
    end
    if (ack_i && irq_req_o) begin
      e6 = irq_exp.pop_front();
      `CHK({irq_id_o, irq_level_o}, e6)
    end
    rd_seen <= rd_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    rd_exp.push_back(e);
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask

  task automatic bw(input logic [7:0] r, input logic [2:0] s, input logic v);
    @(posedge clock_i);
    bit_reg_i <= r;
    bit_sel_i <= s;
    bit_val_i <= v;
    bit_wr_i <= 1'b1;
    @(posedge clock_i);
    bit_wr_i <= 1'b0;
  endtask

  task automatic put_all();
    wr(ADDR_ENABLE_A, en_a);
    wr(ADDR_ENABLE_B, en_b);
    wr(ADDR_PRIO_LOW_A, pl_a);
    wr(ADDR_PRIO_HIGH_A, ph_a);
    wr(ADDR_PRIO_LOW_B, pl_b);
    wr(ADDR_PRIO_HIGH_B, ph_b);
    rd(ADDR_ENABLE_A, en_a);
    rd(ADDR_ENABLE_B, en_b);
    rd(ADDR_PRIO_LOW_A, pl_a);
    rd(ADDR_PRIO_HIGH_A, ph_a);
    rd(ADDR_PRIO_LOW_B, pl_b);
    rd(ADDR_PRIO_HIGH_B, ph_b);
  endtask

  // Winner from the shadow registers; thr is level plus one in service
  function automatic logic [6:0] win(input logic [9:0] s);
    int          pp[10] = '{0, 5, 1, 2, 3, 4, 7, 6, 9, 8};
    int          ep[10] = '{0, 5, 1, 2, 3, 4, 8, 6, 10, 9};
    logic [15:0] en, hi, lo;
    logic [1:0]  l, bl;
    logic [3:0]  bi;
    logic        f;
    en = {en_b, en_a};
    hi = {ph_b, ph_a};
    lo = {pl_b, pl_a};
    f = 1'b0;
    bi = 4'h0;
    bl = 2'h0;
    for (int i = 0; i < 10; i++) begin
      l = {hi[pp[i]], lo[pp[i]]};
      if (s[i] && en[ep[i]] && en_a[7] && (!f || l > bl)) begin
        f = 1'b1;
        bi = 4'(i);
        bl = l;
      end
    end
    return {f && ({1'b0, bl} + 3'h1 > thr), bi, bl};
  endfunction

  task automatic req(input logic [9:0] s);
    w = win(s);
    if (w[6]) irq_exp.push_back(w[5:0]);
    @(posedge clock_i);
    src_req_i <= s;
  endtask

  task automatic wack();
    for (int k = 0; k < 12 && ack_i !== 1'b1; k++) @(posedge clock_i);
    tick(2);
  endtask

  task automatic ret();
    @(posedge clock_i);
    ret_cmd <= 1'b1;
    @(posedge clock_i);
    ret_cmd <= 1'b0;
    tick(3);
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(8000 * 100);
    num_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hFFB1));
    tick(20);
    nrst_i <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    // Random settings; reserved bits kept zero as software must
    for (int n = 0; n < 24; n++) begin
      en_a = 8'($urandom()) | 8'h80;
      if (n % 4 == 0) en_a[7] = 1'b0;
      en_b = 8'($urandom()) & 8'h07;
      pl_a = 8'($urandom());
      ph_a = 8'($urandom());
      pl_b = 8'($urandom()) & 8'h03;
      ph_b = 8'($urandom()) & 8'h03;
      lat <= 2'($urandom());
      put_all();
      req(10'($urandom()));
      if (w[6]) begin
        wack();
        `CHK(in_service_o, 4'h1 << w[1:0])
      end else begin
        tick(4);
        `CHK(irq_req_o, 1'b0)
      end
      src_req_i <= 10'h000;
      ret();
      `CHK(in_service_o, 4'h0)
    end
    // Nesting: equal level waits, strictly higher level preempts
    en_a = 8'hFF;
    en_b = 8'h00;
    pl_a = 8'h05;
    ph_a = 8'h02;
    pl_b = 8'h00;
    ph_b = 8'h00;
    put_all();
    req(10'h001);
    wack();
    thr = 3'h2;
    req(10'h009);
    tick(3);
    `CHK(irq_req_o, 1'b0)
    req(10'h00D);
    wack();
    `CHK(in_service_o, 4'h6)
    src_req_i <= 10'h000;
    ret();
    `CHK(in_service_o, 4'h2)
    ret();
    thr = 3'h0;
    // Single-bit writes land where allowed and are refused on high bytes
    bw(ADDR_ENABLE_A, 3'h7, 1'b0);
    bw(ADDR_ENABLE_B, 3'h2, 1'b1);
    bw(ADDR_PRIO_LOW_A, 3'h0, 1'b0);
    bw(ADDR_PRIO_LOW_B, 3'h1, 1'b1);
    rd(ADDR_EVT_STATUS, 8'h03);
    wr(ADDR_EVT_CLEAR, 8'h0F);
    bw(ADDR_PRIO_HIGH_A, 3'h0, 1'b1);
    bw(ADDR_PRIO_HIGH_B, 3'h1, 1'b1);
    rd(ADDR_ENABLE_A, 8'h7F);
    rd(ADDR_ENABLE_B, 8'h04);
    rd(ADDR_PRIO_LOW_A, 8'h04);
    rd(ADDR_PRIO_LOW_B, 8'h02);
    rd(ADDR_PRIO_HIGH_A, 8'h02);
    rd(ADDR_PRIO_HIGH_B, 8'h00);
    rd(ADDR_EVT_STATUS, 8'h08);
    wr(ADDR_EVT_ENABLE, 8'h08);
    tick(2);
    `CHK(event_irq_o, 1'b1)
    wr(ADDR_EVT_ENABLE, 8'h07);
    tick(2);
    `CHK(event_irq_o, 1'b0)
    wr(ADDR_EVT_ENABLE, 8'h08);
    wr(ADDR_EVT_CLEAR, 8'h08);
    tick(2);
    `CHK(event_irq_o, 1'b0)
    rd(ADDR_EVT_STATUS, 8'h00);
    tick(3);
    `CHK(irq_exp.size(), 0)
    print_verdict();
  end
endmodule
